// ---- rtl/tdr_defs.svh ----
// Purpose: offsets, field positions, reset values and sizes of the debug read-out
// Assumes: included by its bare name from package and design files
// Notes: definitions only
`ifndef TDR_DEFS_SVH
`define TDR_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define TDR_ADDR_W 8
`define TDR_OFS_POINTER 8'h00
`define TDR_OFS_READ_WORD 8'h04

// ----------------------------------------------------------------
// pointer register layout and reset
// ----------------------------------------------------------------
`define TDR_PTR_W 16
`define TDR_PTR_RESET 16'h0000
`define TDR_PTR_ENTRY_HI 15
`define TDR_PTR_ENTRY_LO 4
`define TDR_PTR_WORD_HI 3
`define TDR_PTR_WORD_LO 0

// ----------------------------------------------------------------
// word indexes within one entry
// ----------------------------------------------------------------
`define TDR_WORD_FIRST 4'h0
`define TDR_WORD_ONE 4'h1
`define TDR_WORD_TWO 4'h2
`define TDR_WORD_THREE 4'h3
`define TDR_WORD_LAST 4'h6

// ----------------------------------------------------------------
// read word field positions
// ----------------------------------------------------------------
`define TDR_BODY_HI 31
`define TDR_BODY_LO 4
`define TDR_POS_HI 3
`define TDR_POS_LO 2
`define TDR_PTR_FLAG_BIT 1
`define TDR_INFO_FLAG_BIT 0
`define TDR_W3_RSVD_BIT 19
`define TDR_FLAG_OK 1'b0
`define TDR_FLAG_BAD 1'b1

// ----------------------------------------------------------------
// entry store size
// ----------------------------------------------------------------
`define TDR_DEPTH 16
`define TDR_ENTRY_AW 4
`define TDR_ENTRY_W 83
`define TDR_READ_RESET 32'h0000_0000

`endif

// ---- rtl/tdr_pkg.sv ----
// Purpose: types shared by the debug read-out design files
// Assumes: tdr_defs.svh on the include path
// Notes: none
`include "tdr_defs.svh"

package tdr_pkg;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TDR_TYPE_XLATE_ON = 2'h0,
		TDR_TYPE_XLATE_OFF = 2'h1,
		TDR_TYPE_STREAM_BYPASS = 2'h2,
		TDR_TYPE_UNIDENT_FAULT = 2'h3
	} tdr_entry_type_e;

	typedef enum logic [1:0] {
		TDR_POS_MIDDLE = 2'h0,
		TDR_POS_ENTRY_FIRST = 2'h1,
		TDR_POS_ENTRY_LAST = 2'h2,
		TDR_POS_TLB_FIRST = 2'h3
	} tdr_word_pos_e;

	// ----------------------------------------------------------------
	// one cached translation
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] asid;
		logic nonsecureStateFlag;
		tdr_entry_type_e entryType;
		logic [8:0] lookupVa;
		logic [35:0] physAddr;
		logic userCacheMaintEnable;
		logic ctxEnable;
		logic stage2WideRegime;
		logic stage1WideRegime;
		logic stage1LongDescriptor;
		logic [6:0] ctxIndex;
		logic [2:0] stage2PageSize;
		logic [2:0] stage1PageSize;
		logic notGlobal;
	} tdr_entry_s;

	// ----------------------------------------------------------------
	// all state of the read-out block outside the entry store
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`TDR_PTR_W-1:0] pointer;
		logic [`TDR_DEPTH-1:0] entryValid;
		logic [31:0] readData;
	} tdr_state_s;

endpackage

// ---- rtl/tdr_entry_mem.sv ----
// Purpose: storage of cached translation entries for debug read-out
// Assumes: one write and one read port on clk
// Notes: read data are registered; memory contents have no reset
`include "tdr_defs.svh"

module tdr_entry_mem #(
	parameter int WIDTH = `TDR_ENTRY_W,
	parameter int DEPTH = `TDR_DEPTH,
	parameter int AW = `TDR_ENTRY_AW
) (
	// clock
	input wire logic clk,
	// write side
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	// read side
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] store [DEPTH];

	// ----------------------------------------------------------------
	// one write port per entry, registered read
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_entry
			always_ff @(posedge clk) begin
				if (wrEn && (wrAddr == AW'(gi))) begin
					store[gi] <= wrData;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		rdData <= store[rdAddr];
	end

endmodule // tdr_entry_mem

// ---- rtl/tdr_readout.sv ----
// Purpose: formats cached translations into debug read words 1 to 3
// Assumes: fill port driven by the translation logic; secure flag per access
// Notes: words 0 and 4 to 6 return status bits with a zero body
//
// Summary of operation
// - word 1 bits 31:16 hold the ASID, bit 15 the non-secure state flag.
// - word 1 bits 14:13 hold entry type: on, off, stream bypass, unidentified fault.
// - word 1 bits 12:4 hold the nine-bit lookup virtual address slice.
// - word 2 bits 31:4 hold physical address bits 39:12.
// - word 3 bit 31 holds the user cache maintenance enable.
// - word 3 bit 30 holds the context bank enable, one meaning enabled.
// - word 3 bit 27 long descriptor, bits 26:20 context index, bit 19 reserved.
// - word 3 bits 18:16 hold the stage 2 page size code.
// - word 3 bits 15:13 hold the stage 1 page size code.
// - word 3 bit 12 holds the not-global attribute.
// - word 3 bits 11:4 hold physical address bits 47:40.
// - every word ends with position bits 3:2, pointer flag 1, info flag 0.
// - position reads middle 00, entry first 01, entry last 10, TLB first 11.
// - pointer bits 15:4 select the entry, bits 3:0 the word.
// - pointer and read word registers answer secure accesses only.
//
// Chosen here: strobed register access and the register addresses.
`include "tdr_defs.svh"

module tdr_readout (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [`TDR_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic regSecure,
	output logic [31:0] regReadData,
	// entry fill port
	input wire logic fillWrite,
	input wire logic [`TDR_ENTRY_AW-1:0] fillIndex,
	input wire logic fillValid,
	input wire logic [15:0] fillAsid,
	input wire logic fillNonsecureStateFlag,
	input wire logic [1:0] fillEntryType,
	input wire logic [8:0] fillLookupVa,
	input wire logic [35:0] fillPhysAddr,
	input wire logic fillUserCacheMaintEnable,
	input wire logic fillCtxEnable,
	input wire logic fillStage2WideRegime,
	input wire logic fillStage1WideRegime,
	input wire logic fillStage1LongDescriptor,
	input wire logic [6:0] fillCtxIndex,
	input wire logic [2:0] fillStage2PageSize,
	input wire logic [2:0] fillStage1PageSize,
	input wire logic fillNotGlobal,
	// debug view
	output logic [`TDR_PTR_W-1:0] debugPointer
);

	// ----------------------------------------------------------------
	// state and decode
	// ----------------------------------------------------------------
	tdr_pkg::tdr_state_s st;
	tdr_pkg::tdr_state_s next_st;
	tdr_pkg::tdr_entry_s fillEntry;
	tdr_pkg::tdr_entry_s memEntry;
	logic [`TDR_ENTRY_W-1:0] memData;
	logic [11:0] entrySel;
	logic [3:0] wordSel;
	logic inRange;
	logic entryOk;
	logic wordKnown;
	logic [27:0] wordBody;
	tdr_pkg::tdr_word_pos_e wordPos;
	logic pointerFlag;
	logic infoFlag;
	logic [31:0] formatted;
	logic ptrHit;
	logic dataHit;

	assign entrySel = st.pointer[`TDR_PTR_ENTRY_HI:`TDR_PTR_ENTRY_LO];
	assign wordSel = st.pointer[`TDR_PTR_WORD_HI:`TDR_PTR_WORD_LO];
	assign ptrHit = (regAddr == `TDR_OFS_POINTER) && regSecure;
	assign dataHit = (regAddr == `TDR_OFS_READ_WORD) && regSecure;

	// ----------------------------------------------------------------
	// fill entry assembly and storage
	// ----------------------------------------------------------------
	always_comb begin
		fillEntry.asid = fillAsid;
		fillEntry.nonsecureStateFlag = fillNonsecureStateFlag;
		fillEntry.entryType = tdr_pkg::tdr_entry_type_e'(fillEntryType);
		fillEntry.lookupVa = fillLookupVa;
		fillEntry.physAddr = fillPhysAddr;
		fillEntry.userCacheMaintEnable = fillUserCacheMaintEnable;
		fillEntry.ctxEnable = fillCtxEnable;
		fillEntry.stage2WideRegime = fillStage2WideRegime;
		fillEntry.stage1WideRegime = fillStage1WideRegime;
		fillEntry.stage1LongDescriptor = fillStage1LongDescriptor;
		fillEntry.ctxIndex = fillCtxIndex;
		fillEntry.stage2PageSize = fillStage2PageSize;
		fillEntry.stage1PageSize = fillStage1PageSize;
		fillEntry.notGlobal = fillNotGlobal;
	end

	// read address follows the next pointer so the word is ready when read
	tdr_entry_mem #(
		.WIDTH(`TDR_ENTRY_W),
		.DEPTH(`TDR_DEPTH),
		.AW(`TDR_ENTRY_AW)
	) u_mem (
		.clk(clk),
		.wrEn(fillWrite),
		.wrAddr(fillIndex),
		.wrData(fillEntry),
		.rdAddr(next_st.pointer[`TDR_PTR_ENTRY_LO+`TDR_ENTRY_AW-1:`TDR_PTR_ENTRY_LO]),
		.rdData(memData)
	);

	assign memEntry = tdr_pkg::tdr_entry_s'(memData);

	// ----------------------------------------------------------------
	// word formatting
	// ----------------------------------------------------------------
	always_comb begin
		inRange = (entrySel < 12'(`TDR_DEPTH));
		entryOk = inRange && st.entryValid[entrySel[`TDR_ENTRY_AW-1:0]];
		wordKnown = (wordSel == `TDR_WORD_ONE) || (wordSel == `TDR_WORD_TWO)
			|| (wordSel == `TDR_WORD_THREE);
		wordBody = 28'h0000000;
		if (entryOk) begin
			case (wordSel)
				`TDR_WORD_ONE: begin
					wordBody = {memEntry.asid,
						memEntry.nonsecureStateFlag,
						memEntry.entryType,
						memEntry.lookupVa};
				end
				`TDR_WORD_TWO: begin
					wordBody = memEntry.physAddr[27:0];
				end
				`TDR_WORD_THREE: begin
					wordBody = {memEntry.userCacheMaintEnable,
						memEntry.ctxEnable,
						memEntry.stage2WideRegime,
						memEntry.stage1WideRegime,
						memEntry.stage1LongDescriptor,
						memEntry.ctxIndex,
						1'b0,
						memEntry.stage2PageSize,
						memEntry.stage1PageSize,
						memEntry.notGlobal,
						memEntry.physAddr[35:28]};
				end
				default: begin
					wordBody = 28'h0000000;
				end
			endcase
		end
		// position of the selected word
		if (wordSel == `TDR_WORD_FIRST) begin
			wordPos = (entrySel == 12'h000) ? tdr_pkg::TDR_POS_TLB_FIRST
				: tdr_pkg::TDR_POS_ENTRY_FIRST;
		end else if (wordSel == `TDR_WORD_LAST) begin
			wordPos = tdr_pkg::TDR_POS_ENTRY_LAST;
		end else begin
			wordPos = tdr_pkg::TDR_POS_MIDDLE;
		end
		pointerFlag = inRange ? `TDR_FLAG_OK : `TDR_FLAG_BAD;
		infoFlag = (entryOk && wordKnown) ? `TDR_FLAG_OK : `TDR_FLAG_BAD;
		formatted = {wordBody, wordPos, pointerFlag, infoFlag};
	end

	// ----------------------------------------------------------------
	// register port and next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.readData = `TDR_READ_RESET;
		if (regWrite && ptrHit) begin
			next_st.pointer = regWriteData[`TDR_PTR_W-1:0];
		end
		if (regRead && ptrHit) begin
			next_st.readData = {16'h0000, st.pointer};
		end else if (regRead && dataHit) begin
			next_st.readData = formatted;
		end
		if (fillWrite) begin
			next_st.entryValid[fillIndex] = fillValid;
		end
		if (sys_rst) begin
			next_st.pointer = `TDR_PTR_RESET;
			next_st.entryValid = '0;
			next_st.readData = `TDR_READ_RESET;
		end
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign regReadData = st.readData;
	assign debugPointer = st.pointer;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_ptr_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regWrite && regSecure && regAddr == `TDR_OFS_POINTER)
		|=> (st.pointer == $past(regWriteData[15:0])))
		else $error("pointer write not taken");

	chk_nonsec_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regWrite && !regSecure) |=> $stable(st.pointer))
		else $error("non-secure write changed pointer");

	chk_nonsec_read: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && !regSecure) |=> (regReadData == 32'h00000000))
		else $error("non-secure read returned data");

	chk_idle_zero: assert property (
		@(posedge clk) disable iff (sys_rst)
		!regRead |=> (regReadData == 32'h00000000))
		else $error("read data outside the answer cycle");

	chk_word3_rsvd: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[`TDR_W3_RSVD_BIT] == 1'b0))
		else $error("reserved bit of word 3 set");

	chk_pos_first: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && wordSel == 4'h0 && entrySel != 12'h000)
		|=> (regReadData[3:2] == 2'h1))
		else $error("first word position wrong");

	chk_pos_tlb_first: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && st.pointer == 16'h0000)
		|=> (regReadData[3:2] == 2'h3))
		else $error("TLB first word position wrong");

	chk_pos_last: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && wordSel == 4'h6) |=> (regReadData[3:2] == 2'h2))
		else $error("last word position wrong");

	chk_ptr_range: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entrySel >= 12'(`TDR_DEPTH))
		|=> (regReadData[1] == 1'b1 && regReadData[31:4] == 28'h0000000))
		else $error("out of range pointer not flagged");

	chk_ptr_readback: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && ptrHit) |=> (regReadData == {16'h0000, $past(st.pointer)}))
		else $error("pointer read-back wrong");

	chk_fill_valid: assert property (
		@(posedge clk) disable iff (sys_rst)
		(fillWrite && fillValid) ##1 (regRead && dataHit && wordSel == 4'h2
		&& entrySel == 12'($past(fillIndex)) && $stable(st.pointer))
		|=> (regReadData[0] == 1'b0))
		else $error("filled entry reads as invalid");

	chk_word1_asid: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_ONE)
		|=> (regReadData[31:15] == $past({memEntry.asid, memEntry.nonsecureStateFlag})))
		else $error("word 1 identifier or state misplaced");

	chk_word1_type: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_ONE)
		|=> (regReadData[14:13] == $past(memEntry.entryType)))
		else $error("word 1 entry type misplaced");

	chk_word1_va: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_ONE)
		|=> (regReadData[12:4] == $past(memEntry.lookupVa)))
		else $error("word 1 lookup address misplaced");

	chk_word2_pa: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_TWO)
		|=> (regReadData[31:4] == $past(memEntry.physAddr[27:0])))
		else $error("word 2 physical address misplaced");

	chk_word3_cmo: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[31] == $past(memEntry.userCacheMaintEnable)))
		else $error("word 3 maintenance enable misplaced");

	chk_word3_ctx_en: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[30] == $past(memEntry.ctxEnable)))
		else $error("word 3 context enable misplaced");

	chk_word3_regime: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[29:28] == $past({memEntry.stage2WideRegime, memEntry.stage1WideRegime})))
		else $error("word 3 regime flags misplaced");

	chk_word3_ctx_idx: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[27:20] == $past({memEntry.stage1LongDescriptor, memEntry.ctxIndex})))
		else $error("word 3 context index misplaced");

	chk_word3_s2_page: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[18:16] == $past(memEntry.stage2PageSize)))
		else $error("word 3 stage 2 page size misplaced");

	chk_word3_s1_page: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[15:13] == $past(memEntry.stage1PageSize)))
		else $error("word 3 stage 1 page size misplaced");

	chk_word3_global: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[12] == $past(memEntry.notGlobal)))
		else $error("word 3 not-global flag misplaced");

	chk_word3_pa_hi: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && entryOk && wordSel == `TDR_WORD_THREE)
		|=> (regReadData[11:4] == $past(memEntry.physAddr[35:28])))
		else $error("word 3 upper physical address misplaced");

	chk_body_zero: assert property (
		@(posedge clk) disable iff (sys_rst)
		(regRead && dataHit && !(entryOk && wordKnown))
		|=> (regReadData[31:4] == 28'h0000000))
		else $error("body of an unfilled word not zero");

endmodule // tdr_readout

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the debug read-out words of cached translations
// Assumes: tdr_defs.svh on the include path; register port answers one cycle after a read
// Notes: expected words are built here from the field layout, not from the design
`include "tdr_defs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [`TDR_ADDR_W-1:0] regAddr = '0;
	logic [31:0] regWriteData = '0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic regSecure = 1'b0;
	logic [31:0] regReadData;
	logic fillWrite = 1'b0;
	logic [`TDR_ENTRY_AW-1:0] fillIndex = '0;
	logic fillValid = 1'b0;
	tdr_pkg::tdr_entry_s fillEntry = '0;
	logic [`TDR_PTR_W-1:0] debugPointer;
	tdr_pkg::tdr_entry_s ents [16];
	logic vld [16];
	int failures = 0;
	int check_count = 0;

	tdr_readout u_dut (
		.clk(clk), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
		.regRead(regRead), .regSecure(regSecure), .regReadData(regReadData),
		.fillWrite(fillWrite), .fillIndex(fillIndex), .fillValid(fillValid),
		.fillAsid(fillEntry.asid), .fillNonsecureStateFlag(fillEntry.nonsecureStateFlag),
		.fillEntryType(fillEntry.entryType), .fillLookupVa(fillEntry.lookupVa),
		.fillPhysAddr(fillEntry.physAddr),
		.fillUserCacheMaintEnable(fillEntry.userCacheMaintEnable),
		.fillCtxEnable(fillEntry.ctxEnable), .fillStage2WideRegime(fillEntry.stage2WideRegime),
		.fillStage1WideRegime(fillEntry.stage1WideRegime),
		.fillStage1LongDescriptor(fillEntry.stage1LongDescriptor),
		.fillCtxIndex(fillEntry.ctxIndex), .fillStage2PageSize(fillEntry.stage2PageSize),
		.fillStage1PageSize(fillEntry.stage1PageSize), .fillNotGlobal(fillEntry.notGlobal),
		.debugPointer(debugPointer)
	);

	initial begin
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// access tasks and compares
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic sec);
		@(posedge clk);
		regAddr <= a;
		regWriteData <= d;
		regSecure <= sec;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic sec, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regSecure <= sec;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		d = regReadData;
	endtask

	task automatic fill(input logic [3:0] i, input logic v, input tdr_pkg::tdr_entry_s e);
		@(posedge clk);
		fillWrite <= 1'b1;
		fillIndex <= i;
		fillValid <= v;
		fillEntry <= e;
		@(posedge clk);
		fillWrite <= 1'b0;
		ents[i] = e;
		vld[i] = v;
		repeat (2) @(posedge clk);
	endtask

	task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// ----------------------------------------------------------------
	// expected values
	// ----------------------------------------------------------------
	function automatic tdr_pkg::tdr_entry_s mk(input logic [3:0] i);
		tdr_pkg::tdr_entry_s e;
		e.asid = 16'hc3a0 ^ {i, 12'h5a1};
		e.nonsecureStateFlag = i[0];
		e.entryType = tdr_pkg::tdr_entry_type_e'(i[1:0]);
		e.lookupVa = 9'h1a5 ^ {5'h00, i};
		e.physAddr = {i, 32'h8765_4321 ^ {28'h0, i}};
		e.userCacheMaintEnable = i[0];
		e.ctxEnable = i[1];
		e.stage2WideRegime = i[2];
		e.stage1WideRegime = i[3];
		e.stage1LongDescriptor = ~i[0];
		e.ctxIndex = {3'h5, i};
		e.stage2PageSize = i[2:0];
		e.stage1PageSize = ~i[2:0];
		e.notGlobal = i[1];
		return e;
	endfunction

	function automatic logic [31:0] expWord(input logic [15:0] p);
		logic [11:0] en;
		logic [3:0] w;
		logic inr;
		logic ok;
		logic [1:0] pos;
		logic [27:0] body;
		tdr_pkg::tdr_entry_s e;
		en = p[15:4];
		w = p[3:0];
		inr = en < 12'h010;
		ok = inr && vld[en[3:0]] && w >= 4'h1 && w <= 4'h3;
		e = ents[en[3:0]];
		pos = (w == 4'h0) ? ((en == 12'h000) ? 2'h3 : 2'h1) : ((w == 4'h6) ? 2'h2 : 2'h0);
		body = '0;
		if (ok && w == 4'h1) body = {e.asid, e.nonsecureStateFlag, e.entryType, e.lookupVa};
		if (ok && w == 4'h2) body = e.physAddr[27:0];
		if (ok && w == 4'h3) begin
			body = {e.userCacheMaintEnable, e.ctxEnable, e.stage2WideRegime, e.stage1WideRegime,
				e.stage1LongDescriptor, e.ctxIndex, 1'b0, e.stage2PageSize, e.stage1PageSize,
				e.notGlobal, e.physAddr[35:28]};
		end
		return {body, pos, ~inr, ~ok};
	endfunction

	task automatic sweep(input logic [15:0] p);
		logic [31:0] d;
		logic [31:0] e;
		e = expWord(p);
		wr(8'h00, {16'h0000, p}, 1'b1);
		rd(8'h04, 1'b1, d);
		chk32("word", e, d);
		chk32("status", {28'h0, e[3:0]}, {28'h0, d[3:0]});
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#20000;
		failures++;
		$display("CHECK FAILED watchdog expected done seen hang");
		summarize();
	end

	initial begin
		logic [31:0] d;
		for (int i = 0; i < 16; i++) vld[i] = 1'b0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk16("pointer", 16'h0000, debugPointer);
		rd(8'h04, 1'b1, d);
		chk32("word", 32'h0000_000d, d);
		$display("test reset done");
		for (int i = 0; i < 16; i++) fill(i[3:0], 1'b1, mk(i[3:0]));
		for (int en = 0; en < 17; en++) begin
			for (int w = 0; w < 8; w++) sweep({en[11:0], w[3:0]});
		end
		$display("test sweep done");
		fill(4'h9, 1'b0, mk(4'h9));
		for (int w = 0; w < 4; w++) sweep({12'h009, w[3:0]});
		sweep(16'hfff3);
		// a read in the cycle right after the fill of its own entry
		wr(8'h00, 32'h0000_0092, 1'b1);
		@(posedge clk);
		fillWrite <= 1'b1;
		fillIndex <= 4'h9;
		fillValid <= 1'b1;
		fillEntry <= mk(4'h9);
		@(posedge clk);
		fillWrite <= 1'b0;
		regAddr <= 8'h04;
		regSecure <= 1'b1;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk32("refill", 32'h0000_0000, {28'h0, regReadData[3:0]});
		vld[9] = 1'b1;
		sweep(16'h0092);
		$display("test invalid done");
		wr(8'h00, 32'hffff_0051, 1'b1);
		@(posedge clk);
		chk16("pointer", 16'h0051, debugPointer);
		rd(8'h00, 1'b1, d);
		chk32("ptrread", 32'h0000_0051, d);
		wr(8'h00, 32'h0000_0032, 1'b0);
		wr(8'h04, 32'h0000_0033, 1'b1);
		wr(8'h08, 32'h0000_0034, 1'b1);
		@(posedge clk);
		chk16("pointer", 16'h0051, debugPointer);
		rd(8'h04, 1'b0, d);
		chk32("nonsecure", 32'h0000_0000, d);
		rd(8'h08, 1'b1, d);
		chk32("unmapped", 32'h0000_0000, d);
		rd(8'h04, 1'b1, d);
		chk32("word", expWord(16'h0051), d);
		@(posedge clk);
		#1;
		chk32("idle", 32'h0000_0000, regReadData);
		$display("test refusals done");
		summarize();
	end

endmodule // testbench
